// >>> dv/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic                         sys_clk;
   logic                         sys_rst;
   lqm_pkg::lqm_bus_req_type     busReq;
   logic [lqm_pkg::DATA_W-1:0]   busRdData;
   lqm_pkg::lqm_params_type      dspParams;
   logic                         link100Valid;
   logic                         signalDetectOption;
   logic                         powerDown;
   logic [lqm_pkg::VAR_W-1:0]    varianceSum;
   logic                         varianceLoad;
   logic                         dspRestart;
   logic                         linkDrop;
   logic                         irq;
   int                           failures = 0;
   int                           tests_run = 0;
   int                           restartCnt = 0;
   int                           dropCnt = 0;
   logic [15:0]                  rdVal;
   logic [15:0]                  rdHi;

   lqm_link_quality_monitor i_lqm_link_quality_monitor (
      .sys_clk            (sys_clk),
      .sys_rst            (sys_rst),
      .busReq             (busReq),
      .busRdData          (busRdData),
      .dspParams          (dspParams),
      .link100Valid       (link100Valid),
      .signalDetectOption (signalDetectOption),
      .powerDown          (powerDown),
      .varianceSum        (varianceSum),
      .varianceLoad       (varianceLoad),
      .dspRestart         (dspRestart),
      .linkDrop           (linkDrop),
      .irq                (irq)
   );

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // Pulses are counted, so their exact cycle does not matter here
   always @(posedge sys_clk) begin
      if (dspRestart === 1'b1) restartCnt++;
      if (linkDrop === 1'b1) dropCnt++;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      busReq.wr     <= 1'b1;
      busReq.addr   <= a;
      busReq.wrData <= d;
      @(posedge sys_clk);
      busReq.wr     <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      busReq.rd   <= 1'b1;
      busReq.addr <= a;
      @(posedge sys_clk);
      busReq.rd   <= 1'b0;
      #1;
      d = busRdData;
   endtask : rd_reg

   // Two reads with no gap, the way the variance pair is meant to be taken
   task automatic rd_pair(input logic [4:0] a, output logic [15:0] lo, output logic [15:0] hi);
      @(posedge sys_clk);
      busReq.rd   <= 1'b1;
      busReq.addr <= a;
      @(posedge sys_clk);
      #1;
      lo = busRdData;
      @(posedge sys_clk);
      busReq.rd   <= 1'b0;
      #1;
      hi = busRdData;
   endtask : rd_pair

   task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
      rd_reg(a, rdVal);
      check(rdVal, exp);
   endtask : rd_chk

   task automatic set_thr(input int sel, input logic hi, input logic [15:0] d);
      wr_reg(lqm_pkg::ADDR_THR_CTRL, {11'h000, 1'b0, sel[2:0], hi});
      wr_reg(lqm_pkg::ADDR_THR_DATA, d);
   endtask : set_thr

   task automatic load_var(input logic [31:0] v);
      @(posedge sys_clk);
      varianceSum  <= v;
      varianceLoad <= 1'b1;
      @(posedge sys_clk);
      varianceLoad <= 1'b0;
   endtask : load_var

   // One violation episode, removed again before any clearing read
   task automatic pulse_param(input int i, input logic [15:0] v);
      @(posedge sys_clk);
      dspParams[i] <= v;
      repeat (2) @(posedge sys_clk);
      dspParams[i] <= 16'h4000;
      repeat (3) @(posedge sys_clk);
      #1;
   endtask : pulse_param

   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : complete_run

   initial begin
      #200000;
      failures++;
      complete_run();
   end

   initial begin
      sys_rst            = 1'b1;
      busReq             = '0;
      dspParams          = {5{16'h4000}};
      link100Valid       = 1'b1;
      signalDetectOption = 1'b0;
      powerDown          = 1'b0;
      varianceSum        = 32'h0000_0000;
      varianceLoad       = 1'b0;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;

      rd_chk(lqm_pkg::ADDR_MON_CTRL, 16'h0000);
      rd_chk(lqm_pkg::ADDR_VAR_CTRL, 16'h0000);
      rd_chk(lqm_pkg::ADDR_VAR_DATA, 16'h0000);
      rd_chk(5'h05, 16'h0000);
      check({15'h0000, irq}, 16'h0000);

      // Frozen two-read access while a second sum arrives
      load_var(32'hbeef_1234);
      rd_chk(lqm_pkg::ADDR_VAR_CTRL, 16'h8000);
      wr_reg(lqm_pkg::ADDR_VAR_CTRL, 16'h0008);
      load_var(32'h1111_2222);
      rd_pair(lqm_pkg::ADDR_VAR_DATA, rdVal, rdHi);
      check(rdVal, 16'h1234);
      check(rdHi, 16'hbeef);
      rd_chk(lqm_pkg::ADDR_VAR_CTRL, 16'h0000);
      rd_chk(lqm_pkg::ADDR_INT_STATUS, 16'h0002);

      // Enable, all restarts, and an attempt on the warning bits
      wr_reg(lqm_pkg::ADDR_INT_MASK, 16'h0001);
      wr_reg(lqm_pkg::ADDR_MON_CTRL, 16'hffff);
      rd_chk(lqm_pkg::ADDR_MON_CTRL, 16'hfc00);
      for (int v = 0; v < 2; v++) begin
         @(posedge sys_clk);
         dspParams <= {5{(v == 0) ? 16'hffff : 16'h0000}};
         repeat (3) @(posedge sys_clk);
         rd_chk(lqm_pkg::ADDR_MON_CTRL, 16'hfc00);
      end
      @(posedge sys_clk);
      dspParams <= {5{16'h4000}};
      for (int i = 0; i < 5; i++) begin
         set_thr(i, 1'b1, 16'h8000);
         set_thr(i, 1'b0, 16'h0100);
      end
      wr_reg(lqm_pkg::ADDR_THR_CTRL, 16'h0005);
      rd_chk(lqm_pkg::ADDR_THR_DATA, 16'h8000);
      @(posedge sys_clk);
      powerDown <= 1'b1;
      set_thr(0, 1'b1, 16'h0001);
      powerDown <= 1'b0;
      wr_reg(lqm_pkg::ADDR_THR_CTRL, 16'h0001);
      rd_chk(lqm_pkg::ADDR_THR_DATA, 16'h8000);

      // No monitoring without a valid link
      @(posedge sys_clk);
      link100Valid <= 1'b0;
      pulse_param(0, 16'h9000);
      link100Valid <= 1'b1;
      rd_chk(lqm_pkg::ADDR_MON_CTRL, 16'hfc00);
      check(restartCnt[15:0], 16'h0000);

      for (int i = 0; i < 5; i++) begin
         signalDetectOption <= (i >= 3);
         pulse_param(i, 16'h9000);
         check({15'h0000, irq}, 16'h0001);
         rd_chk(lqm_pkg::ADDR_MON_CTRL, 16'hfc00 | (16'h0001 << (2 * i + 1)));
         rd_chk(lqm_pkg::ADDR_INT_STATUS, 16'h0001);
         pulse_param(i, 16'h0010);
         check({15'h0000, irq}, 16'h0001);
         rd_chk(lqm_pkg::ADDR_MON_CTRL, 16'hfc00 | (16'h0001 << (2 * i)));
         rd_chk(lqm_pkg::ADDR_INT_STATUS, 16'h0001);
         rd_chk(lqm_pkg::ADDR_MON_CTRL, 16'hfc00);
         check({15'h0000, irq}, 16'h0000);
      end
      check(restartCnt[15:0], 16'h000a);
      check(dropCnt[15:0], 16'h0006);

      // Masked event, restarts off
      wr_reg(lqm_pkg::ADDR_MON_CTRL, 16'h8000);
      wr_reg(lqm_pkg::ADDR_INT_MASK, 16'h0000);
      pulse_param(0, 16'h9000);
      check({15'h0000, irq}, 16'h0000);
      wr_reg(lqm_pkg::ADDR_INT_MASK, 16'h0001);
      repeat (2) @(posedge sys_clk);
      #1;
      check({15'h0000, irq}, 16'h0001);
      rd_chk(lqm_pkg::ADDR_INT_STATUS, 16'h0001);
      rd_chk(lqm_pkg::ADDR_MON_CTRL, 16'h8002);
      check(restartCnt[15:0], 16'h000a);

      // One-cycle violation landing on the clearing read
      @(posedge sys_clk);
      busReq.rd    <= 1'b1;
      busReq.addr  <= lqm_pkg::ADDR_MON_CTRL;
      dspParams[1] <= 16'h0010;
      @(posedge sys_clk);
      busReq.rd    <= 1'b0;
      dspParams[1] <= 16'h4000;
      #1;
      check(busRdData, 16'h8000);
      rd_chk(lqm_pkg::ADDR_MON_CTRL, 16'h8004);
      rd_chk(lqm_pkg::ADDR_MON_CTRL, 16'h8000);

      // Sampled parameter value
      @(posedge sys_clk);
      dspParams[2] <= 16'h1357;
      wr_reg(lqm_pkg::ADDR_THR_CTRL, 16'h0014);
      rd_chk(lqm_pkg::ADDR_THR_DATA, 16'h1357);
      complete_run();
   end
endmodule : tb_top

// >>> src/lqm_link_quality_monitor.sv
module lqm_link_quality_monitor (
   // Clock and reset
   input  wire logic                         sys_clk,
   input  wire logic                         sys_rst,
   // Register port
   input  wire lqm_pkg::lqm_bus_req_type     busReq,
   output logic [lqm_pkg::DATA_W-1:0]        busRdData,
   // DSP and link status
   input  wire lqm_pkg::lqm_params_type      dspParams,
   input  wire logic                         link100Valid,
   input  wire logic                         signalDetectOption,
   input  wire logic                         powerDown,
   // Variance computation
   input  wire logic [lqm_pkg::VAR_W-1:0]    varianceSum,
   input  wire logic                         varianceLoad,
   // Actions
   output logic                              dspRestart,
   output logic                              linkDrop,
   output logic                              irq
);
   localparam int unsigned PN = lqm_pkg::PARAM_NUM;
   localparam int unsigned DW = lqm_pkg::DATA_W;

   function automatic logic hit(input logic                      strobe,
                                input logic [lqm_pkg::ADDR_W-1:0] addr,
                                input logic [lqm_pkg::ADDR_W-1:0] target);
      return strobe && (addr == target);
   endfunction : hit

   // Decoded accesses
   logic ctrlRead;
   logic ctrlWrite;
   logic varRead;
   logic varCtrlWrite;
   logic statusRead;
   logic maskWrite;
   logic thrCtrlWrite;
   logic thrDataWrite;

   assign ctrlRead     = hit(busReq.rd, busReq.addr, lqm_pkg::ADDR_MON_CTRL);
   assign ctrlWrite    = hit(busReq.wr, busReq.addr, lqm_pkg::ADDR_MON_CTRL);
   assign varRead      = hit(busReq.rd, busReq.addr, lqm_pkg::ADDR_VAR_DATA);
   assign varCtrlWrite = hit(busReq.wr, busReq.addr, lqm_pkg::ADDR_VAR_CTRL);
   assign statusRead   = hit(busReq.rd, busReq.addr, lqm_pkg::ADDR_INT_STATUS);
   assign maskWrite    = hit(busReq.wr, busReq.addr, lqm_pkg::ADDR_INT_MASK);
   assign thrCtrlWrite = hit(busReq.wr, busReq.addr, lqm_pkg::ADDR_THR_CTRL);
   assign thrDataWrite = hit(busReq.wr, busReq.addr, lqm_pkg::ADDR_THR_DATA);

   // Control and warning state
   logic                          monEnable;
   logic [PN-1:0]                 restartEn;
   logic [lqm_pkg::WARN_W-1:0]    warn;
   logic [lqm_pkg::WARN_W-1:0]    viol;
   logic [lqm_pkg::WARN_W-1:0]    warnEvt;
   logic [lqm_pkg::WARN_W-1:0]    prevEvt;
   logic [lqm_pkg::WARN_W-1:0]    newEvt;
   logic [lqm_pkg::WARN_W-1:0]    limitOff;
   logic [PN-1:0]                 restartReq;
   logic                          monActive;

   // Threshold storage
   logic [PN-1:0][lqm_pkg::PARAM_W-1:0] thrLow;
   logic [PN-1:0][lqm_pkg::PARAM_W-1:0] thrHigh;
   logic [lqm_pkg::SEL_W-1:0]           thrSel;
   logic                                thrHiSel;
   logic                                sampleMode;
   logic [lqm_pkg::PARAM_W-1:0]         sampledValue;
   logic                                selValid;

   // Variance path
   logic [lqm_pkg::VAR_W-1:0]     varLatch;
   logic                          varReady;
   logic                          varHold;
   lqm_pkg::lqm_var_phase_type    varPhase;
   logic                          varEvt;
   logic                          secondRead;

   // Interrupt
   logic [lqm_pkg::INT_W-1:0]     intStatus;
   logic [lqm_pkg::INT_W-1:0]     intMask;
   logic                          armed;
   logic                          qualEvt;
   logic [DW-1:0]                 next_rdData;

   assign monActive = monEnable && link100Valid;
   assign warnEvt   = monActive ? viol : '0;
   assign newEvt    = warnEvt & ~prevEvt;
   assign selValid  = thrSel <= lqm_pkg::PARAM_LAST;
   assign varEvt    = varianceLoad && !varHold;
   assign secondRead = varRead && (varPhase == lqm_pkg::VAR_HIGH);
   assign qualEvt   = (|warnEvt) && armed;

   genvar gi;
   generate
      for (gi = 0; gi < PN; gi++) begin : g_param
         lqm_threshold_check u_check (
            .value    (dspParams[gi]),
            .low      (thrLow[gi]),
            .high     (thrHigh[gi]),
            .highViol (viol[2*gi+1]),
            .lowViol  (viol[2*gi])
         );
         assign limitOff[2*gi+1] = thrHigh[gi] == lqm_pkg::THR_HIGH_RST;
         assign limitOff[2*gi]   = thrLow[gi] == lqm_pkg::THR_LOW_RST;
         // Only a fresh violation restarts, so a stuck one does not loop
         assign restartReq[gi] = restartEn[gi] && |newEvt[2*gi+1 -: 2];
      end
   endgenerate

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         monEnable <= 1'b0;
         restartEn <= '0;
      end else if (ctrlWrite) begin
         monEnable <= busReq.wrData[lqm_pkg::MON_ENABLE_BIT];
         restartEn <= busReq.wrData[lqm_pkg::RESTART_LSB +: PN];
      end
   end

   // Write data never reaches the warning bits
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         warn <= '0;
      end else begin
         warn <= (ctrlRead ? '0 : warn) | warnEvt;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         prevEvt <= '0;
      end else begin
         prevEvt <= warnEvt;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         dspRestart <= 1'b0;
         linkDrop   <= 1'b0;
      end else begin
         dspRestart <= |restartReq;
         linkDrop   <= (|restartReq) && !signalDetectOption;
      end
   end

   // Thresholds reset to the disabled ends of the range
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < PN; i++) begin
            thrLow[i]  <= lqm_pkg::THR_LOW_RST;
            thrHigh[i] <= lqm_pkg::THR_HIGH_RST;
         end
      end else if (thrDataWrite && selValid && !powerDown) begin
         if (thrHiSel) begin
            thrHigh[thrSel] <= busReq.wrData;
         end else begin
            thrLow[thrSel] <= busReq.wrData;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         thrSel     <= '0;
         thrHiSel   <= 1'b0;
         sampleMode <= 1'b0;
      end else if (thrCtrlWrite) begin
         thrSel     <= busReq.wrData[lqm_pkg::THR_SEL_LSB +: lqm_pkg::SEL_W];
         thrHiSel   <= busReq.wrData[lqm_pkg::THR_HI_BIT];
         sampleMode <= busReq.wrData[lqm_pkg::THR_SAMPLE_BIT];
      end
   end

   // Snapshot keeps the value steady across the later read
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sampledValue <= '0;
      end else if (thrCtrlWrite && busReq.wrData[lqm_pkg::THR_SAMPLE_BIT]) begin
         sampledValue <= (busReq.wrData[lqm_pkg::THR_SEL_LSB +: lqm_pkg::SEL_W] <= lqm_pkg::PARAM_LAST)
                       ? dspParams[busReq.wrData[lqm_pkg::THR_SEL_LSB +: lqm_pkg::SEL_W]] : '0;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         varLatch <= '0;
      end else if (varEvt) begin
         varLatch <= varianceSum;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         varReady <= 1'b0;
      end else if (varEvt) begin
         varReady <= 1'b1;
      end else if (secondRead) begin
         varReady <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         varHold <= 1'b0;
      end else if (secondRead) begin
         varHold <= 1'b0;
      end else if (varCtrlWrite) begin
         varHold <= busReq.wrData[lqm_pkg::VAR_HOLD_BIT];
      end
   end

   // Setting hold or loading a new sum restarts the pair at the low half
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         varPhase <= lqm_pkg::VAR_LOW;
      end else if (varEvt || varCtrlWrite) begin
         varPhase <= lqm_pkg::VAR_LOW;
      end else if (varRead) begin
         case (varPhase)
            lqm_pkg::VAR_LOW: begin
               varPhase <= lqm_pkg::VAR_HIGH;
            end
            lqm_pkg::VAR_HIGH: begin
               varPhase <= lqm_pkg::VAR_LOW;
            end
            default: begin
               varPhase <= lqm_pkg::VAR_LOW;
            end
         endcase
      end
   end

   // One interrupt per episode until the control register is read
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         armed <= 1'b1;
      end else if (qualEvt) begin
         armed <= 1'b0;
      end else if (ctrlRead) begin
         armed <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         intStatus <= '0;
      end else begin
         intStatus <= (statusRead ? '0 : intStatus) | {varEvt, qualEvt};
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         intMask <= '0;
      end else if (maskWrite) begin
         intMask <= busReq.wrData[lqm_pkg::INT_W-1:0];
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(intStatus & intMask);
      end
   end

   always_comb begin
      next_rdData = lqm_pkg::RD_IDLE;
      case (busReq.addr)
         lqm_pkg::ADDR_MON_CTRL: begin
            next_rdData[lqm_pkg::MON_ENABLE_BIT]          = monEnable;
            next_rdData[lqm_pkg::RESTART_LSB +: PN]       = restartEn;
            next_rdData[lqm_pkg::WARN_W-1:0]              = warn;
         end
         lqm_pkg::ADDR_VAR_CTRL: begin
            next_rdData[lqm_pkg::VAR_READY_BIT]           = varReady;
            next_rdData[lqm_pkg::VAR_HOLD_BIT]            = varHold;
         end
         lqm_pkg::ADDR_VAR_DATA: begin
            next_rdData = (varPhase == lqm_pkg::VAR_HIGH)
                        ? varLatch[lqm_pkg::VAR_W-1:DW] : varLatch[DW-1:0];
         end
         lqm_pkg::ADDR_INT_STATUS: begin
            next_rdData[lqm_pkg::INT_W-1:0]               = intStatus;
         end
         lqm_pkg::ADDR_INT_MASK: begin
            next_rdData[lqm_pkg::INT_W-1:0]               = intMask;
         end
         lqm_pkg::ADDR_THR_CTRL: begin
            next_rdData[lqm_pkg::THR_HI_BIT]              = thrHiSel;
            next_rdData[lqm_pkg::THR_SEL_LSB +: lqm_pkg::SEL_W] = thrSel;
            next_rdData[lqm_pkg::THR_SAMPLE_BIT]          = sampleMode;
         end
         lqm_pkg::ADDR_THR_DATA: begin
            if (sampleMode) begin
               next_rdData = sampledValue;
            end else if (selValid) begin
               next_rdData = thrHiSel ? thrHigh[thrSel] : thrLow[thrSel];
            end
         end
         default: begin
            next_rdData = lqm_pkg::RD_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         busRdData <= lqm_pkg::RD_IDLE;
      end else begin
         busRdData <= busReq.rd ? next_rdData : lqm_pkg::RD_IDLE;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   sequence s_first_read;
      varRead && (varPhase == lqm_pkg::VAR_LOW) && varHold;
   endsequence

   sequence s_second_read;
      varRead && (varPhase == lqm_pkg::VAR_HIGH);
   endsequence

   a_var_first_low: assert property (s_first_read |=> busRdData == $past(varLatch[DW-1:0]))
      else $error("first variance read did not return low half");
   a_var_pair_high: assert property (s_first_read ##1 s_second_read
                                     |=> busRdData == $past(varLatch[lqm_pkg::VAR_W-1:DW]))
      else $error("second variance read did not return high half");
   a_var_pair_clear: assert property ((s_second_read and !varianceLoad) |=> !varReady && !varHold)
      else $error("ready or hold survived the second read");
   a_var_frozen: assert property (varHold && !secondRead |=> $stable(varLatch))
      else $error("variance value changed while held");
   a_var_ready_set: assert property (varianceLoad && !varHold |=> varReady && varLatch == $past(varianceSum))
      else $error("new variance value did not raise ready");
   a_warn_read_clear: assert property (ctrlRead && !(|warnEvt) |=> warn == '0)
      else $error("warnings not cleared by control read");
   a_warn_keep_event: assert property (ctrlRead && (|warnEvt) |=> (warn & $past(warnEvt)) == $past(warnEvt))
      else $error("event lost during clearing read");
   a_warn_idle_hold: assert property (!monActive && !ctrlRead |=> $stable(warn))
      else $error("warnings changed while monitor inactive");
   a_warn_no_write: assert property (ctrlWrite && !(|warnEvt) |=> $stable(warn))
      else $error("write disturbed warning bits");
   a_limit_off: assert property (!(|(viol & limitOff)))
      else $error("disabled threshold reported a violation");
   a_irq_raise: assert property (qualEvt && intMask[lqm_pkg::INT_QUAL_BIT] && !statusRead ##1 !statusRead
                                 |=> irq)
      else $error("unmasked violation did not raise interrupt");
   a_rearm_read: assert property (!armed && ctrlRead && !(|warnEvt) |=> armed)
      else $error("interrupt not re-armed by control read");
   a_rearm_raise: assert property (armed && (|warnEvt) |=> intStatus[lqm_pkg::INT_QUAL_BIT])
      else $error("armed violation did not set status");
   a_restart_drop: assert property ((|restartReq) |=> dspRestart && (linkDrop == !$past(signalDetectOption)))
      else $error("restart or link drop mismatch");
endmodule : lqm_link_quality_monitor

// >>> src/lqm_pkg.sv
package lqm_pkg;
   localparam int unsigned ADDR_W    = 5;
   localparam int unsigned DATA_W    = 16;
   localparam int unsigned PARAM_NUM = 5;
   localparam int unsigned PARAM_W   = 16;
   localparam int unsigned WARN_W    = 2 * PARAM_NUM;
   localparam int unsigned VAR_W     = 2 * DATA_W;
   localparam int unsigned INT_W     = 2;
   localparam int unsigned SEL_W     = 3;

   // Register addresses
   localparam logic [ADDR_W-1:0] ADDR_INT_STATUS = 5'h12;
   localparam logic [ADDR_W-1:0] ADDR_INT_MASK   = 5'h13;
   localparam logic [ADDR_W-1:0] ADDR_VAR_CTRL   = 5'h1a;
   localparam logic [ADDR_W-1:0] ADDR_VAR_DATA   = 5'h1b;
   localparam logic [ADDR_W-1:0] ADDR_MON_CTRL   = 5'h1d;
   localparam logic [ADDR_W-1:0] ADDR_THR_CTRL   = 5'h1e;
   localparam logic [ADDR_W-1:0] ADDR_THR_DATA   = 5'h1f;

   // Field positions
   localparam int unsigned MON_ENABLE_BIT  = 15;
   localparam int unsigned RESTART_LSB     = 10;
   localparam int unsigned VAR_READY_BIT   = 15;
   localparam int unsigned VAR_HOLD_BIT    = 3;
   localparam int unsigned THR_HI_BIT      = 0;
   localparam int unsigned THR_SEL_LSB     = 1;
   localparam int unsigned THR_SAMPLE_BIT  = 4;
   localparam int unsigned INT_QUAL_BIT    = 0;
   localparam int unsigned INT_VAR_BIT     = 1;

   // Reset values and last parameter index
   localparam logic [DATA_W-1:0]  RD_IDLE      = 16'h0000;
   localparam logic [PARAM_W-1:0] THR_LOW_RST  = 16'h0000;
   localparam logic [PARAM_W-1:0] THR_HIGH_RST = 16'hffff;
   localparam logic [SEL_W-1:0]   PARAM_LAST   = 3'h4;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wrData;
      logic              wr;
      logic              rd;
   } lqm_bus_req_type;

   // Index 0 equalizer, 1 gain, 2 wander, 3 offset, 4 freq control
   typedef logic [PARAM_NUM-1:0][PARAM_W-1:0] lqm_params_type;

   typedef enum logic [1:0] {
      VAR_LOW  = 2'b01,
      VAR_HIGH = 2'b10
   } lqm_var_phase_type;
endpackage : lqm_pkg

// >>> src/lqm_threshold_check.sv
module lqm_threshold_check (
   // Current value
   input  wire logic [lqm_pkg::PARAM_W-1:0] value,
   // Limits
   input  wire logic [lqm_pkg::PARAM_W-1:0] low,
   input  wire logic [lqm_pkg::PARAM_W-1:0] high,
   // Results
   output logic                             highViol,
   output logic                             lowViol
);
   // Limit at the end of the range means the check is off
   always_comb begin
      highViol = (high != lqm_pkg::THR_HIGH_RST) && (value > high);
      lowViol  = (low != lqm_pkg::THR_LOW_RST) && (value < low);
   end
endmodule : lqm_threshold_check
